// ### design/ptc_conf_if.sv
// Interface carrying one shaped waveform and its confirmation results.
`timescale 1ns/1ns
interface ptc_conf_if;
    // Shaped waveform level, confirmed pulse, rejected pulse and resample busy.
    logic wave;
    logic confirm;
    logic noise;
    logic busy;

    // The confirmer reads the waveform and reports results.
    modport confirmer (
        input wave,
        output confirm,
        output noise,
        output busy
    );

    // The user drives the waveform and reads results.
    modport user (
        output wave,
        input confirm,
        input noise,
        input busy
    );
endinterface

// ### design/ptc_edge_confirm.sv
// Rising edge detector with delayed resample confirmation for one shaped waveform.
`timescale 1ns/1ns
module ptc_edge_confirm
    import ptc_pkg::*;
#(
    parameter int DELAY_CYC = RESAMPLE_CYC
) (
    // Clock, reset and enable.
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Waveform and results.
    ptc_conf_if.confirmer cf
);

    // ************************************************************
    // Parameter check.
    // ************************************************************
    // The resample instant must stay inside the tolerance band and the counter.
    if (DELAY_CYC < RESAMPLE_MIN_CYC || DELAY_CYC > RESAMPLE_MAX_CYC || DELAY_CYC >= (1 << DLY_W)) begin
        $error("ptc_edge_confirm: DELAY_CYC outside the legal resample window");
    end

    localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(DELAY_CYC - 1);

    // ************************************************************
    // State.
    // ************************************************************
    typedef struct packed {
        logic prev;
        logic first;
        logic busy;
        logic [DLY_W-1:0] cnt;
        logic confirm;
        logic noise;
    } ptc_ec_state_t;

    ptc_ec_state_t st;
    ptc_ec_state_t next_st;

    // Edges are looked for only while idle, so a bouncing edge cannot restart the wait.
    always_comb begin
        next_st = st;
        next_st.prev = cf.wave;
        next_st.confirm = 1'b0;
        next_st.noise = 1'b0;
        if (!st.busy) begin
            if (cf.wave == LEVEL_SENSED && st.prev != LEVEL_SENSED) begin
                next_st.busy = 1'b1;
                next_st.first = cf.wave;
                next_st.cnt = '0;
            end
        end else if (st.cnt == DLY_LAST) begin
            next_st.busy = 1'b0;
            if (cf.wave == st.first) begin
                next_st.confirm = 1'b1;
            end else begin
                next_st.noise = 1'b1;
            end
        end else begin
            next_st.cnt = st.cnt + DLY_W'(1);
        end
    end

    // Register the state; the first sample after reset sees the line as already high
    // so a level that is high at release is not taken for an edge.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st <= '{prev: LEVEL_SENSED, first: 1'b0, busy: 1'b0, cnt: '0, confirm: 1'b0, noise: 1'b0};
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    // Results come straight from flip-flops.
    assign cf.confirm = st.confirm;
    assign cf.noise = st.noise;
    assign cf.busy = st.busy;

endmodule

// ### design/ptc_pkg.sv
// Package holding the constants and types of the print timing pulse confirmation logic.
package ptc_pkg;

    // ************************************************************
    // Clock and resample timing.
    // ************************************************************
    // Controller clock rate in MHz.
    localparam int CLK_MHZ = 100;
    // Nominal resample delay after a candidate edge, in microseconds.
    localparam int T_RESAMPLE_US = 15;
    // Allowed deviation of the resample instant, in microseconds.
    localparam int T_TOL_US = 5;
    // Resample delay in clock cycles.
    localparam int RESAMPLE_CYC = T_RESAMPLE_US * CLK_MHZ;
    // Earliest legal resample instant in cycles, a least time rounded up.
    localparam int RESAMPLE_MIN_CYC = (T_RESAMPLE_US - T_TOL_US) * CLK_MHZ;
    // Latest legal resample instant in cycles, a longest time rounded down.
    localparam int RESAMPLE_MAX_CYC = (T_RESAMPLE_US + T_TOL_US) * CLK_MHZ;
    // Width of the resample delay counter.
    localparam int DLY_W = 12;

    // ************************************************************
    // Waveform polarity and counter widths.
    // ************************************************************
    // Shaped level that means the detector sees its target.
    localparam logic LEVEL_SENSED = 1'b1;
    // Default width of the column strobe counter.
    localparam int COL_CNT_W = 16;
    // Default width of the dot line counter.
    localparam int LINE_CNT_W = 8;

    // ************************************************************
    // Print cycle sequencing states.
    // ************************************************************
    typedef enum logic [1:0] {
        CY_IDLE  = 2'b00,
        CY_ARMED = 2'b01,
        CY_PEND  = 2'b10,
        CY_RUN   = 2'b11
    } ptc_cyc_t;

endpackage

// ### design/ptc_top.sv
// Top of the print timing pulse confirmation logic: column strobes, line index and cycle counting.
`timescale 1ns/1ns

// Summary of operation
// - A rising edge of the shaped column waveform is a candidate strobe.
// - Resample the shaped waveform 15 us after the candidate edge.
// - A strobe is confirmed only when both samples agree.
// - Disagreeing samples mean noise; no strobe is produced.
// - Confirmed strobes pace solenoid firing and the fast feed trigger.
// - A confirmed line index clears the strobe count per character cycle.
// - The line index is applied only at the first strobe of line 1.
// - No further clearing until the whole print cycle has finished.
// - Shaped waveforms are inverted relative to detector outputs.
// - Sensor supply switches on and off together with the motor drive.
// - The line index is confirmed by the same edge and resample check.
module ptc_top
    import ptc_pkg::*;
#(
    parameter int CNT_W = COL_CNT_W,
    parameter int LINE_W = LINE_CNT_W,
    parameter int DELAY_CYC = RESAMPLE_CYC
) (
    // Clock, reset and enable.
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    // Shaped waveforms, high while the target is sensed.
    input wire logic TIMING_WAVE_I,
    input wire logic RESET_WAVE_I,
    // Print sequencer controls.
    input wire logic MOTOR_ON_I,
    input wire logic CYCLE_START_I,
    input wire logic CYCLE_DONE_I,
    // Confirmed pulses.
    output logic COL_STROBE_O,
    output logic LINE_INDEX_O,
    // Noise reports and the ignored index flag.
    output logic COL_NOISE_O,
    output logic LINE_NOISE_O,
    output logic INDEX_IGNORED_O,
    // Counts and status.
    output logic [CNT_W-1:0] COL_COUNT_O,
    output logic [LINE_W-1:0] DOT_LINE_O,
    output logic [1:0] CYCLE_STATE_O,
    output logic CYCLE_ACTIVE_O,
    // Sensor supply enable.
    output logic SENSOR_PWR_O
);

    // ************************************************************
    // Parameter check.
    // ************************************************************
    // Counters need at least two bits to be of any use.
    if (CNT_W < 2 || CNT_W > 32 || LINE_W < 2 || LINE_W > 32) begin
        $error("ptc_top: counter widths must lie between 2 and 32");
    end

    // ************************************************************
    // Edge confirmation for both detectors.
    // ************************************************************
    ptc_conf_if col_if ();
    ptc_conf_if idx_if ();

    // The shaped waveforms are already inverted by the shaping stage, so high means sensed.
    assign col_if.wave = TIMING_WAVE_I;
    assign idx_if.wave = RESET_WAVE_I;

    // Column timing waveform confirmer.
    ptc_edge_confirm #(
        .DELAY_CYC(DELAY_CYC)
    ) u_col_confirm (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .cf(col_if)
    );

    // Line index waveform confirmer uses the same edge and resample scheme.
    ptc_edge_confirm #(
        .DELAY_CYC(DELAY_CYC)
    ) u_idx_confirm (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .cf(idx_if)
    );

    // ************************************************************
    // Counting helper.
    // ************************************************************
    // Counters saturate instead of wrapping, so an overlong cycle shows a stuck value, not a small one.
    function automatic logic [31:0] sat_inc(input logic [31:0] val, input int width);
        logic [31:0] top_val;
        top_val = (width >= 32) ? 32'hFFFFFFFF : ((32'h00000001 << width) - 32'h00000001);
        sat_inc = (val >= top_val) ? val : (val + 32'h00000001);
    endfunction

    // ************************************************************
    // State.
    // ************************************************************
    typedef struct packed {
        ptc_cyc_t cyc;
        logic [CNT_W-1:0] col_cnt;
        logic [LINE_W-1:0] line_cnt;
        logic strobe;
        logic index;
        logic col_noise;
        logic line_noise;
        logic ignored;
        logic pwr;
    } ptc_top_state_t;

    ptc_top_state_t st;
    ptc_top_state_t next_st;

    logic col_ok;
    logic idx_ok;
    logic [CNT_W-1:0] col_inc;
    logic [LINE_W-1:0] line_inc;

    // Confirmed events and incremented counts.
    assign col_ok = col_if.confirm;
    assign idx_ok = idx_if.confirm;
    assign col_inc = CNT_W'(sat_inc(32'(st.col_cnt), CNT_W));
    assign line_inc = LINE_W'(sat_inc(32'(st.line_cnt), LINE_W));

    // Cycle sequencing: arm on start, hold an index until the first strobe, then run untouched.
    always_comb begin
        next_st = st;
        next_st.strobe = col_ok;
        next_st.index = idx_ok;
        next_st.col_noise = col_if.noise;
        next_st.line_noise = idx_if.noise;
        next_st.ignored = 1'b0;
        next_st.pwr = MOTOR_ON_I;
        if (col_ok) begin
            next_st.col_cnt = col_inc;
        end
        case (st.cyc)
            CY_IDLE: begin
                if (CYCLE_START_I) begin
                    next_st.cyc = CY_ARMED;
                end
            end
            CY_ARMED: begin
                if (CYCLE_DONE_I) begin
                    next_st.cyc = CY_IDLE;
                end else if (idx_ok && col_ok) begin
                    next_st.col_cnt = {{(CNT_W-1){1'b0}}, 1'b1};
                    next_st.line_cnt = {{(LINE_W-1){1'b0}}, 1'b1};
                    next_st.cyc = CY_RUN;
                end else if (idx_ok) begin
                    next_st.line_cnt = {{(LINE_W-1){1'b0}}, 1'b1};
                    next_st.cyc = CY_PEND;
                end
            end
            CY_PEND: begin
                // The index takes effect only with the first confirmed strobe of line 1.
                if (CYCLE_DONE_I) begin
                    next_st.cyc = CY_IDLE;
                end else if (col_ok) begin
                    next_st.col_cnt = {{(CNT_W-1){1'b0}}, 1'b1};
                    next_st.cyc = CY_RUN;
                end
            end
            CY_RUN: begin
                // Later index pulses only advance the dot line and raise the ignored flag; the count is left alone.
                if (CYCLE_DONE_I) begin
                    next_st.cyc = CY_IDLE;
                end else if (idx_ok) begin
                    next_st.line_cnt = line_inc;
                    next_st.ignored = 1'b1;
                end
            end
            default: begin
                next_st.cyc = CY_IDLE;
            end
        endcase
    end

    // Register the state.
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            st <= '{cyc: CY_IDLE, col_cnt: '0, line_cnt: '0, strobe: 1'b0, index: 1'b0,
                    col_noise: 1'b0, line_noise: 1'b0, ignored: 1'b0, pwr: 1'b0};
        end else if (CE_I) begin
            st <= next_st;
        end
    end

    // ************************************************************
    // Outputs, all from flip-flops except CYCLE_ACTIVE_O, which is decoded from the cycle state.
    // ************************************************************
    assign COL_STROBE_O = st.strobe;
    assign LINE_INDEX_O = st.index;
    assign COL_NOISE_O = st.col_noise;
    assign LINE_NOISE_O = st.line_noise;
    assign INDEX_IGNORED_O = st.ignored;
    assign COL_COUNT_O = st.col_cnt;
    assign DOT_LINE_O = st.line_cnt;
    assign CYCLE_STATE_O = st.cyc;
    assign CYCLE_ACTIVE_O = (st.cyc == CY_RUN);
    assign SENSOR_PWR_O = st.pwr;

endmodule

// ### dv/ptc_mech_model.sv
// Model of the mechanism's column and line detectors with the shaping stage.
`timescale 1ns/1ns
module ptc_mech_model (
    // Clock.
    input wire logic clk_i,
    // Shaped waveforms.
    output logic timing_wave_o,
    output logic reset_wave_o
);
    // Raw open-collector outputs; the pull-ups hold them high when nothing is sensed.
    logic [1:0] raw_n = 2'b11;
    // The shaping stage inverts the raw level.
    assign timing_wave_o = ~raw_n[0];
    assign reset_wave_o = ~raw_n[1];
    // Sense a target for hi cycles; one line call is one dot line, column lag stays under 100 us.
    task automatic sense(input int sel, input int lag, input int hi);
        fork
            begin
                repeat (lag) @(posedge clk_i);
                raw_n[sel] <= 1'b0;
                repeat (hi) @(posedge clk_i);
                raw_n[sel] <= 1'b1;
            end
        join_none
    endtask
endmodule

// ### dv/ptc_top_monitor.sv
// Checker for the pulse confirmation top.
`timescale 1ns/1ns
module ptc_top_monitor
    import ptc_pkg::*;
#(
    parameter int CNT_W = COL_CNT_W,
    parameter int LINE_W = LINE_CNT_W,
    parameter int DELAY_CYC = RESAMPLE_CYC
) (
    // Clock, reset and stimulus.
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    input wire logic CYCLE_DONE_I,
    input wire logic TIMING_WAVE_I,
    input wire logic RESET_WAVE_I,
    input wire logic MOTOR_ON_I,
    // Design results.
    input wire logic COL_STROBE_O,
    input wire logic LINE_INDEX_O,
    input wire logic COL_NOISE_O,
    input wire logic LINE_NOISE_O,
    input wire logic INDEX_IGNORED_O,
    input wire logic [CNT_W-1:0] COL_COUNT_O,
    input wire logic [LINE_W-1:0] DOT_LINE_O,
    input wire logic [1:0] CYCLE_STATE_O,
    input wire logic SENSOR_PWR_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    logic [1:0] run, smp, wv, wv_d, p1, due;
    logic [11:0] ct [2];
    assign wv = {RESET_WAVE_I, TIMING_WAVE_I};
    // Shadow confirmers, 0 column and 1 line; a new edge may start right after the resample edge,
    // while the verdict of the old one is still on its way two edges later.
    always_ff @(posedge CLK_I) begin
        for (int i = 0; i < 2; i++) begin
            if (!RST_N_I) begin
                run[i] <= 1'b0;
                p1[i] <= 1'b0;
                due[i] <= 1'b0;
                wv_d[i] <= 1'b1;
            end else begin
                wv_d[i] <= wv[i];
                p1[i] <= run[i] && ct[i] == 12'(DELAY_CYC);
                due[i] <= p1[i];
                if (!run[i] && wv[i] && !wv_d[i]) begin
                    run[i] <= 1'b1;
                    ct[i] <= 12'h001;
                end else if (run[i]) begin
                    ct[i] <= ct[i] + 12'h001;
                    if (ct[i] == 12'(DELAY_CYC)) begin
                        smp[i] <= wv[i];
                        run[i] <= 1'b0;
                    end
                end
            end
        end
    end
    a_col_verdict: assert property (due[0] |-> COL_STROBE_O == smp[0] && COL_NOISE_O == !smp[0])
        else $error("column verdict wrong");
    a_col_no_stray: assert property (COL_STROBE_O || COL_NOISE_O |-> due[0])
        else $error("column result off time");
    a_line_verdict: assert property (due[1] |-> LINE_INDEX_O == smp[1] && LINE_NOISE_O == !smp[1])
        else $error("line verdict wrong");
    a_line_no_stray: assert property (LINE_INDEX_O || LINE_NOISE_O |-> due[1])
        else $error("line result off time");
    a_count_step: assert property (COL_STROBE_O && $past(CYCLE_STATE_O) inside {CY_IDLE, CY_RUN}
        |-> COL_COUNT_O == $past(COL_COUNT_O) + 1'b1) else $error("count step wrong");
    a_first_clear: assert property (COL_STROBE_O && !$past(CYCLE_DONE_I) &&
        ($past(CYCLE_STATE_O) == CY_PEND || LINE_INDEX_O && $past(CYCLE_STATE_O) == CY_ARMED)
        |-> COL_COUNT_O == 1 && CYCLE_STATE_O == CY_RUN) else $error("count not cleared");
    a_index_kept: assert property (LINE_INDEX_O && !COL_STROBE_O && !$past(CYCLE_DONE_I) &&
        $past(CYCLE_STATE_O) == CY_RUN |-> INDEX_IGNORED_O && $stable(COL_COUNT_O) &&
        DOT_LINE_O == $past(DOT_LINE_O) + 1'b1) else $error("index in cycle wrong");
    a_power_follow: assert property ($past(RST_N_I) && $past(CE_I) |-> SENSOR_PWR_O == $past(MOTOR_ON_I))
        else $error("sensor supply wrong");
    a_hold_frozen: assert property (!$past(CE_I) |-> $stable(SENSOR_PWR_O) && $stable(COL_COUNT_O))
        else $error("state moved while disabled");
endmodule
bind ptc_top ptc_top_monitor #(.CNT_W(CNT_W), .LINE_W(LINE_W), .DELAY_CYC(DELAY_CYC)) mon_u (.CLK_I(CLK_I),
    .RST_N_I(RST_N_I), .CE_I(CE_I), .CYCLE_DONE_I(CYCLE_DONE_I),
    .TIMING_WAVE_I(TIMING_WAVE_I), .RESET_WAVE_I(RESET_WAVE_I), .MOTOR_ON_I(MOTOR_ON_I),
    .COL_STROBE_O(COL_STROBE_O), .LINE_INDEX_O(LINE_INDEX_O), .COL_NOISE_O(COL_NOISE_O),
    .LINE_NOISE_O(LINE_NOISE_O), .INDEX_IGNORED_O(INDEX_IGNORED_O), .COL_COUNT_O(COL_COUNT_O),
    .DOT_LINE_O(DOT_LINE_O), .CYCLE_STATE_O(CYCLE_STATE_O), .SENSOR_PWR_O(SENSOR_PWR_O));

// ### dv/tb_ptc_top.sv
// Bench for the pulse confirmation top.
`timescale 1ns/1ns
module tb_ptc_top;
    import ptc_pkg::*;
    logic clk, rst_n, motor, start, done, ce;
    logic tw, rw, cs, li, cn, ln, ig, act, pwr;
    logic [15:0] cnt;
    logic [7:0] dot;
    logic [1:0] st;
    logic [4:0] ev;
    int failures = 0;
    int total_checks = 0;
    int cyc = 0;
    // Result pulses gathered so one wait task serves them all.
    assign ev = {ig, ln, cn, li, cs};
    ptc_mech_model mech_u (.clk_i(clk), .timing_wave_o(tw), .reset_wave_o(rw));
    ptc_top dut_u (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .TIMING_WAVE_I(tw), .RESET_WAVE_I(rw),
        .MOTOR_ON_I(motor), .CYCLE_START_I(start), .CYCLE_DONE_I(done), .COL_STROBE_O(cs),
        .LINE_INDEX_O(li), .COL_NOISE_O(cn), .LINE_NOISE_O(ln), .INDEX_IGNORED_O(ig), .COL_COUNT_O(cnt),
        .DOT_LINE_O(dot), .CYCLE_STATE_O(st), .CYCLE_ACTIVE_O(act), .SENSOR_PWR_O(pwr));
    task automatic test_done();
        if (failures == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    // Wait at least one edge for a result pulse, bounded past the resample latency.
    task automatic wait_ev(input int sel);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (ev[sel] !== 1'b1 && n < 2000);
        chk(16'h0001, 16'(ev[sel]));
    endtask
    // Let both waves fall so the next rise is a fresh edge.
    task automatic settle();
        for (int n = 0; n < 2000 && (tw || rw); n++) @(posedge clk);
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic ctl(input logic s, input logic d);
        @(posedge clk);
        start <= s;
        done <= d;
        @(posedge clk);
        start <= 1'b0;
        done <= 1'b0;
        #1;
    endtask
    task automatic t_free();
        for (int k = 1; k <= 2; k++) begin
            mech_u.sense(0, 1, 1600);
            wait_ev(0);
            chk(16'(k), cnt);
            settle();
        end
    endtask
    task automatic t_noise();
        mech_u.sense(0, 1, 500);
        wait_ev(2);
        chk(16'h0000, 16'(cs));
        chk(16'h0002, cnt);
        settle();
        mech_u.sense(1, 1, 500);
        wait_ev(3);
        chk(16'h0000, 16'(li));
        settle();
    endtask
    task automatic t_cycle();
        ctl(1'b1, 1'b0);
        chk(16'(CY_ARMED), 16'(st));
        mech_u.sense(1, 1, 1600);
        mech_u.sense(0, 300, 1600);
        wait_ev(1);
        chk(16'(CY_PEND), 16'(st));
        wait_ev(0);
        chk(16'h0001, cnt);
        chk(16'h0001, 16'(act));
        settle();
        mech_u.sense(0, 1, 1600);
        wait_ev(0);
        chk(16'h0002, cnt);
        settle();
        mech_u.sense(1, 1, 1600);
        wait_ev(4);
        chk(16'h0002, cnt);
        chk(16'h0002, 16'(dot));
        settle();
        ctl(1'b0, 1'b1);
        chk(16'(CY_IDLE), 16'(st));
    endtask
    task automatic t_same();
        ctl(1'b1, 1'b0);
        mech_u.sense(1, 1, 1600);
        mech_u.sense(0, 1, 1600);
        wait_ev(1);
        chk(16'h0001, 16'(cs));
        chk(16'h0001, cnt);
        chk(16'(CY_RUN), 16'(st));
        settle();
        ctl(1'b0, 1'b1);
    endtask
    task automatic t_power();
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            motor <= !motor;
            #1;
            chk(16'(k), 16'(pwr));
            @(posedge clk);
            #1;
            chk(16'(!k), 16'(pwr));
        end
    endtask
    // Clock enable low freezes the supply flag although the motor input moves.
    task automatic t_hold();
        @(posedge clk);
        ce <= 1'b0;
        motor <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk(16'h0000, 16'(pwr));
        @(posedge clk);
        ce <= 1'b1;
        @(posedge clk);
        #1;
        chk(16'h0001, 16'(pwr));
    endtask
    // Clock and hang guard; the ceiling is about three times the planned run.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            test_done();
        end
    end
    initial begin
        rst_n = 1'b0;
        motor = 1'b0;
        start = 1'b0;
        done = 1'b0;
        ce = 1'b1;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk(16'h0000, cnt);
        chk(16'(CY_IDLE), 16'(st));
        t_power();
        t_hold();
        t_free();
        t_noise();
        t_cycle();
        t_same();
        test_done();
    end
endmodule
